// ### rtl/lcl_logic_cell.v
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "lcl_defines.vh"

module lcl_logic_cell (
	// Clock and reset
	input wire mclk,
	input wire srst,
	// AXI4-Lite write address and data
	input wire [6:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read
	input wire [6:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Data sources, four per cell, cell n uses bits 4n+3..4n
	input wire [15:0] dataSrc,
	// Cell outputs
	output reg [3:0] cellOut
);

	////////////////////////////////////////////////////////////////////////////
	// Configuration storage
	reg [11:0] modeR;
	reg [15:0] polR;
	reg [63:0] sel12R;
	reg [63:0] sel34R;
	reg [3:0] disR;
	reg [6:0] wAddrR;
	reg [31:0] wDataR;
	reg [3:0] wStrbR;
	reg wPendR;
	reg [6:0] rAddrR;
	reg rPendR;

	// One gate: OR of enabled true and negated sources, zero if none enabled
	function gate_or;
		input [7:0] sel;
		input [3:0] d;
		integer k;
		begin
			gate_or = 1'b0;
			for (k = 0; k < 4; k = k + 1) begin
				gate_or = gate_or | (sel[2*k+1] & d[k]);
				gate_or = gate_or | (sel[2*k] & ~d[k]);
			end
		end
	endfunction

	// Address decode helpers
	wire wCellHit = (wAddrR[6] == 1'b0);
	wire [1:0] wCell = wAddrR[5:4];
	wire [1:0] wReg = wAddrR[3:2];
	wire wDisHit = (wAddrR == `LCL_OFF_DISABLE);
	wire wOk = wCellHit | wDisHit;
	wire rCellHit = (rAddrR[6] == 1'b0);
	wire [1:0] rCell = rAddrR[5:4];
	wire [1:0] rReg = rAddrR[3:2];
	wire rDisHit = (rAddrR == `LCL_OFF_DISABLE);

	// Byte-lane merge of a 16-bit register
	function [15:0] merge16;
		input [15:0] old;
		input [31:0] wd;
		input [3:0] st;
		begin
			merge16[7:0] = st[0] ? wd[7:0] : old[7:0];
			merge16[15:8] = st[1] ? wd[15:8] : old[15:8];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Write channel: take address and data together once both are valid, then respond
	always @(posedge mclk) begin
		if (srst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LCL_RESP_OKAY;
			wAddrR <= 7'h00;
			wDataR <= 32'h0000_0000;
			wStrbR <= 4'h0;
			wPendR <= 1'b0;
			modeR <= {4{`LCL_RST_MODE}};
			polR <= {4{`LCL_RST_POL}};
			sel12R <= {4{`LCL_RST_SEL}};
			sel34R <= {4{`LCL_RST_SEL}};
			disR <= `LCL_RST_DIS;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			wPendR <= 1'b0;
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (!s_axi_bvalid && !wPendR && !s_axi_awready && s_axi_awvalid &&
				s_axi_wvalid) begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
				wAddrR <= s_axi_awaddr;
				wDataR <= s_axi_wdata;
				wStrbR <= s_axi_wstrb;
				wPendR <= 1'b1;
			end
			if (wPendR) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wOk ? `LCL_RESP_OKAY : `LCL_RESP_SLVERR;
				if (wCellHit && wStrbR[0]) begin
					case (wReg)
						`LCL_OFF_MODE: modeR[3*wCell +: 3] <= wDataR[2:0];
						`LCL_OFF_POL: polR[4*wCell +: 4] <= wDataR[3:0];
						default: ;
					endcase
				end
				if (wCellHit && wReg == `LCL_OFF_SEL12)
					sel12R[16*wCell +: 16] <= merge16(sel12R[16*wCell +: 16], wDataR, wStrbR);
				if (wCellHit && wReg == `LCL_OFF_SEL34)
					sel34R[16*wCell +: 16] <= merge16(sel34R[16*wCell +: 16], wDataR, wStrbR);
				if (wDisHit && wStrbR[0])
					disR <= wDataR[`LCL_DIS_MSB:`LCL_DIS_LSB];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read channel: one cycle to take the address, one to answer
	always @(posedge mclk) begin
		if (srst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `LCL_RESP_OKAY;
			rAddrR <= 7'h00;
			rPendR <= 1'b0;
		end else begin
			s_axi_arready <= 1'b0;
			rPendR <= 1'b0;
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (!s_axi_rvalid && !rPendR && !s_axi_arready && s_axi_arvalid) begin
				s_axi_arready <= 1'b1;
				rAddrR <= s_axi_araddr;
				rPendR <= 1'b1;
			end
			if (rPendR) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= (rCellHit | rDisHit) ? `LCL_RESP_OKAY : `LCL_RESP_SLVERR;
				s_axi_rdata <= 32'h0000_0000;
				if (rDisHit)
					s_axi_rdata[`LCL_DIS_MSB:`LCL_DIS_LSB] <= disR;
				else if (rCellHit) begin
					case (rReg)
						`LCL_OFF_MODE: begin
							s_axi_rdata[2:0] <= modeR[3*rCell +: 3];
							s_axi_rdata[`LCL_STATE_BIT] <= cellOut[rCell];
						end
						`LCL_OFF_POL: s_axi_rdata[3:0] <= polR[4*rCell +: 4];
						`LCL_OFF_SEL12: s_axi_rdata[15:0] <= sel12R[16*rCell +: 16];
						default: s_axi_rdata[15:0] <= sel34R[16*rCell +: 16];
					endcase
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Four cells
	genvar c;
	generate
		for (c = 0; c < 4; c = c + 1) begin : gCell
			wire [3:0] d = dataSrc[4*c +: 4];
			wire [15:0] s12 = sel12R[16*c +: 16];
			wire [15:0] s34 = sel34R[16*c +: 16];
			wire [3:0] pol = polR[4*c +: 4];
			wire [2:0] mode = modeR[3*c +: 3];
			// Gate outputs after polarity; gate 4 high byte, gate 3 low byte
			wire g1 = gate_or(s12[7:0], d) ^ pol[0];
			wire g2 = gate_or(s12[15:8], d) ^ pol[1];
			wire g3 = gate_or(s34[7:0], d) ^ pol[2];
			wire g4 = gate_or(s34[15:8], d) ^ pol[3];
			reg clkPrevR;
			reg outNxt;
			wire clkRise = g1 & ~clkPrevR;

			// Next output per mode; flip-flop modes clock on gate 1 rising
			always @* begin
				outNxt = cellOut[c];
				case (mode)
					`LCL_MD_ANDOR: outNxt = (g1 & g2) | (g3 & g4);
					`LCL_MD_ORXOR: outNxt = (g1 | g2) ^ (g3 | g4);
					`LCL_MD_AND4: outNxt = g1 & g2 & g3 & g4;
					`LCL_MD_SRLAT: begin
						if (g1 | g2)
							outNxt = 1'b1;
						else if (g3 | g4)
							outNxt = 1'b0;
					end
					`LCL_MD_DFFSR: begin
						if (g4)
							outNxt = 1'b1;
						else if (g3)
							outNxt = 1'b0;
						else if (clkRise)
							outNxt = g2;
					end
					`LCL_MD_DFF2: begin
						if (g3)
							outNxt = 1'b0;
						else if (clkRise)
							outNxt = g2 & g4;
					end
					`LCL_MD_JKFF: begin
						if (g3)
							outNxt = 1'b0;
						else if (clkRise)
							outNxt = (g2 & ~cellOut[c]) | (~g4 & cellOut[c]);
					end
					`LCL_MD_DLAT: begin
						if (g4)
							outNxt = 1'b1;
						else if (g3)
							outNxt = 1'b0;
						else if (g1)
							outNxt = g2;
					end
					default: outNxt = 1'b0;
				endcase
			end

			// Output and gate-1 history; a disabled cell is held cleared
			always @(posedge mclk) begin
				if (srst || disR[c]) begin
					cellOut[c] <= 1'b0;
					clkPrevR <= 1'b0;
				end else begin
					cellOut[c] <= outNxt;
					clkPrevR <= g1;
				end
			end
		end
	endgenerate

endmodule // lcl_logic_cell

// ### rtl/lcl_defines.vh
// How it works
// - Modes 011 to 111 give SR latch, D flip-flops, JK flip-flop, transparent latch.
// - A set gate polarity bit inverts that gate before the logic function.
// - Polarity bits for gates 4..1 sit in bits 3..0; bits 15..4 read zero.
// - A true-enable bit routes the plain data source into its gate.
// - A negated-enable bit routes the inverted data source into its gate.
// - Gate 4 uses bits 15..8, gate 3 bits 7..0, source 4 true first.
// - Disable bits 5..2 switch cells 4..1 off when set.
`ifndef LCL_DEFINES_VH
`define LCL_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Register map: cell n at n*16, one shared disable register after the cells
`define LCL_ADDR_W 7
`define LCL_OFF_MODE 2'h0
`define LCL_OFF_POL 2'h1
`define LCL_OFF_SEL12 2'h2
`define LCL_OFF_SEL34 2'h3
`define LCL_OFF_DISABLE 7'h40

// Field positions
`define LCL_MODE_W 3
`define LCL_STATE_BIT 5
`define LCL_POL_W 4
`define LCL_DIS_LSB 2
`define LCL_DIS_MSB 5

// Reset values
`define LCL_RST_MODE 3'h0
`define LCL_RST_POL 4'h0
`define LCL_RST_SEL 16'h0000
`define LCL_RST_DIS 4'h0

// Mode encodings
`define LCL_MD_ANDOR 3'h0
`define LCL_MD_ORXOR 3'h1
`define LCL_MD_AND4 3'h2
`define LCL_MD_SRLAT 3'h3
`define LCL_MD_DFFSR 3'h4
`define LCL_MD_DFF2 3'h5
`define LCL_MD_JKFF 3'h6
`define LCL_MD_DLAT 3'h7

// Bus responses
`define LCL_RESP_OKAY 2'h0
`define LCL_RESP_SLVERR 2'h2

`endif

// ### test/lcl_logic_cell_sva.sv
`timescale 1ns/1ps
module lcl_logic_cell_sva (
	// Clock and reset
	input logic mclk,
	input logic srst,
	// Register bus
	input logic s_axi_awvalid,
	input logic s_axi_wvalid,
	input logic s_axi_awready,
	input logic s_axi_wready,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic s_axi_arready,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic [31:0] s_axi_rdata,
	// Cell outputs
	input logic [3:0] cellOut
);
	// One clock domain for every check
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	sequence wrTaken;
		s_axi_awready && s_axi_wready;
	endsequence
	chk_ready_pair: assert property (s_axi_awready == s_axi_wready)
		else $error("ready pair split");
	chk_write_answer: assert property (wrTaken |=> s_axi_bvalid && !s_axi_awready)
		else $error("no write response");
	chk_lone_valid: assert property (!(s_axi_awvalid && s_axi_wvalid) |=> !s_axi_awready)
		else $error("lone valid taken");
	chk_read_answer: assert property (s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("no read data");
	chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
		else $error("rdata moved");
	chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper bits set");
	chk_reset_out: assert property (disable iff (1'b0) srst |=> cellOut == 4'h0)
		else $error("output after reset");
endmodule // lcl_logic_cell_sva
bind lcl_logic_cell lcl_logic_cell_sva chk (.mclk, .srst, .s_axi_awvalid, .s_axi_wvalid,
	.s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .cellOut);

// ### test/lcl_src_model.sv
`timescale 1ns/1ps
module lcl_src_model (
	// Clock
	input logic mclk,
	// Wanted levels and source pins
	input logic [15:0] srcWant,
	output logic [15:0] dataSrc = 16'h0000
);
	// Sources change just after an edge, like other peripherals
	always @(posedge mclk) begin
		dataSrc <= srcWant;
	end
endmodule // lcl_src_model

// ### test/tb_lcl_logic_cell.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin testsRun++; if ((a) !== (e)) begin nErrors++; \
	$display("Error %s expected %h seen %h", n, e, a); end end
module tb_lcl_logic_cell;
	logic mclk = 0, srst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [6:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdat, rdata;
	logic [15:0] srcWant = 0, dataSrc;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] bresp, rresp, lastResp, rr;
	logic awready, wready, bvalid, arready, rvalid;
	logic [3:0] cellOut;
	logic [2:0] cur, m;
	int nErrors = 0, testsRun = 0, cyc = 0;
	// Sequential steps: mode, source levels, expected output
	logic [7:0] seqTab [0:25] = '{8'h63, 8'h61, 8'h68, 8'h60, 8'h84, 8'h87, 8'h83, 8'h81,
		8'h88, 8'h91, 8'hA8, 8'hA0, 8'hB7, 8'hA1, 8'hA6, 8'hC0, 8'hC7, 8'hC1, 8'hD2, 8'hC0,
		8'hD7, 8'hE7, 8'hE2, 8'hE0, 8'hF1, 8'hE8};
	always #2 mclk = ~mclk;
	lcl_src_model src (.mclk, .srcWant, .dataSrc);
	lcl_logic_cell dut (.mclk, .srst, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dataSrc,
		.cellOut);
	////////////////////////////////////////////////////////////////////////////////
	// Bus write, waits for the response
	task wr(input logic [6:0] a, input logic [15:0] d);
		@(posedge mclk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge mclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (!bvalid);
		lastResp = bresp;
		bready <= 0;
	endtask
	// Bus read, waits for the data
	task rd(input logic [6:0] a);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge mclk);
			if (arready) arvalid <= 0;
		end while (!rvalid);
		rdat = rdata;
		rr = rresp;
		rready <= 0;
	endtask
	// Expected combinational result from gate levels
	function logic ex(input logic [2:0] md, input logic [3:0] g);
		case (md)
			3'h0: ex = (g[0] & g[1]) | (g[2] & g[3]);
			3'h1: ex = (g[0] | g[1]) ^ (g[2] | g[3]);
			default: ex = &g;
		endcase
	endfunction
	// Drive source levels and let them settle
	task put(input logic [3:0] v);
		srcWant <= {12'h000, v};
		repeat (4) @(posedge mclk);
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", testsRun, nErrors);
		if (nErrors == 0 && testsRun > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Cuts a hang short
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			nErrors++;
			give_verdict();
		end
	end
	// Main sequence
	initial begin
		repeat (5) @(posedge mclk);
		srst <= 0;
		rd(7'h04);
		`CHK("pol", 32'h0000_0000, rdat)
		rd(7'h40);
		`CHK("dis", 32'h0000_0000, rdat)
		wr(7'h04, 16'hFFFF);
		rd(7'h04);
		`CHK("pol", 32'h0000_000F, rdat)
		wr(7'h0C, 16'hA5C3);
		rd(7'h0C);
		`CHK("sel34", 32'h0000_A5C3, rdat)
		// Only the gate 4 byte lane is written, gate 3 keeps its sources
		wstrb <= 4'h2;
		wr(7'h0C, 16'h3C00);
		wstrb <= 4'hF;
		rd(7'h0C);
		`CHK("lane", 32'h0000_3CC3, rdat)
		wr(7'h44, 16'h0001);
		`CHK("wresp", 2'h2, lastResp)
		rd(7'h44);
		`CHK("rresp", 2'h2, rr)
		$display("test registers done");
		for (int k = 0; k < 3; k++) begin
			wr(7'h08, k == 1 ? 16'h0401 : 16'h0802);
			wr(7'h0C, k == 1 ? 16'h4010 : 16'h8020);
			wr(7'h04, k == 2 ? 16'h000F : 16'h0000);
			for (m = 0; m < 3; m++) begin
				wr(7'h00, {13'h0000, m});
				for (int v = 0; v < 16; v++) begin
					put(v[3:0]);
					`CHK("comb", ex(m, k == 0 ? v[3:0] : ~v[3:0]), cellOut[0])
				end
			end
		end
		$display("test gates done");
		wr(7'h04, 16'h0000);
		put(4'h0);
		cur = 3'h2;
		for (int i = 0; i < 26; i++) begin
			if (seqTab[i][7:5] !== cur) begin
				cur = seqTab[i][7:5];
				wr(7'h00, {13'h0000, cur});
			end
			put(seqTab[i][4:1]);
			`CHK("seq", seqTab[i][0], cellOut[0])
		end
		$display("test sequential done");
		wr(7'h40, 16'h003C);
		rd(7'h40);
		`CHK("dis", 32'h0000_003C, rdat)
		put(4'h8);
		`CHK("off", 4'h0, cellOut)
		wr(7'h40, 16'h0000);
		put(4'h8);
		`CHK("on", 1'b1, cellOut[0])
		rd(7'h00);
		`CHK("mode", 32'h0000_0027, rdat)
		$display("test disable done");
		// Cell four: AND of gate 1 on source 1 with three empty inverted gates
		wr(7'h30, 16'h0002);
		wr(7'h38, 16'h0002);
		wr(7'h34, 16'h000E);
		srcWant <= 16'h1008;
		repeat (4) @(posedge mclk);
		`CHK("cell4 on", 1'b1, cellOut[3])
		wr(7'h40, 16'h0020);
		repeat (4) @(posedge mclk);
		`CHK("cell4 off", 4'h1, cellOut)
		$display("test cell four done");
		give_verdict();
	end
endmodule // tb_lcl_logic_cell
